/* design/spc_top.sv */
// Pin control for three serial port instances: register file, pin
// direction and gpio muxing, global output-off.
// Assumes a simple register port on mclk and asynchronous pin inputs.
//
// Chosen here: the plain strobed port and the placing of the registers.
module spc_top
	import spc_pkg::*;
(
	input  wire logic        mclk,        // System clock, 125 MHz
	input  wire logic        rst_n,       // Async reset, active low
	input  wire logic        off_n,       // Global output-off, active low
	input  wire logic [7:0]  addr,        // Register byte address
	input  wire logic [15:0] wdata,       // Register write data
	input  wire logic        wr,          // Write strobe
	input  wire logic        rd,          // Read strobe
	output logic      [15:0] rdata,       // Read data, cycle after rd
	input  wire logic [2:0]  rx_bit_clock_pin_i,  // Rx clock pin in
	output logic      [2:0]  rx_bit_clock_pin_o,  // Rx clock pin out
	output logic      [2:0]  rx_bit_clock_pin_oe, // Rx clock pin enable
	input  wire logic [2:0]  rx_serial_data_pin_i, // Rx data pin in
	input  wire logic [2:0]  rx_frame_sync_pin_i, // Rx sync pin in
	output logic      [2:0]  rx_frame_sync_pin_o, // Rx sync pin out
	output logic      [2:0]  rx_frame_sync_pin_oe, // Rx sync pin enable
	input  wire logic [2:0]  tx_bit_clock_pin_i,  // Tx clock pin in
	output logic      [2:0]  tx_bit_clock_pin_o,  // Tx clock pin out
	output logic      [2:0]  tx_bit_clock_pin_oe, // Tx clock pin enable
	output logic      [2:0]  tx_serial_data_o,    // Tx data pin out
	output logic      [2:0]  tx_serial_data_oe    // Tx data pin enable
);

	spc_top_st_t      s_r;
	spc_top_st_t      s_nxt;
	logic [2:0]       p_int_clk;
	logic [2:0]       p_int_fs;
	logic [2:0]       p_tx_bit;
	logic [2:0][15:0] p_rx_word;
	logic [2:0]       p_rx_done;
	logic [2:0][3:0]  p_lvl;
	logic [1:0]       a_inst;
	logic [3:0]       a_reg;

	assign a_inst = addr[5:4];
	assign a_reg  = addr[3:0];

	// ------------------------------------------------------------------
	// Serial engines, one per instance
	// ------------------------------------------------------------------
	for (genvar g = 0; g < `SPC_NUM_INST; g++) begin : g_port
		spc_port u_port (
			.mclk       (mclk),
			.rst_n      (rst_n),
			.rx_clk_dir (s_r.pin_control_register[g][`SPC_PCR_RX_CLK_DIR]),
			.tx_clk_dir (s_r.pin_control_register[g][`SPC_PCR_TX_CLK_DIR]),
			.rx_fs_dir  (s_r.pin_control_register[g][`SPC_PCR_RX_FS_DIR]),
			.rx_gpio    (s_r.pin_control_register[g][`SPC_PCR_RX_GPIO]),
			.tx_gpio    (s_r.pin_control_register[g][`SPC_PCR_TX_GPIO]),
			.tx_word    (s_r.txw[g]),
			.rck_pin    (rx_bit_clock_pin_i[g]),
			.rdt_pin    (rx_serial_data_pin_i[g]),
			.rfs_pin    (rx_frame_sync_pin_i[g]),
			.xck_pin    (tx_bit_clock_pin_i[g]),
			.int_clk    (p_int_clk[g]),
			.int_fs     (p_int_fs[g]),
			.tx_bit     (p_tx_bit[g]),
			.rx_word    (p_rx_word[g]),
			.rx_done    (p_rx_done[g]),
			.pin_lvl    (p_lvl[g])
		);
	end

	// ------------------------------------------------------------------
	// Registers, flags and pin drivers
	// ------------------------------------------------------------------
	always_comb begin
		s_nxt       = s_r;
		s_nxt.rdata = 16'h0000;
		// Off is a pin, so it passes two flops before use
		s_nxt.off_s = {s_r.off_s[0], off_n};

		for (int i = 0; i < `SPC_NUM_INST; i++) begin
			// Register writes
			if (wr && a_inst == 2'(i)) begin
				if (a_reg == `SPC_OFF_PCR) begin
					s_nxt.pin_control_register[i] = wdata & `SPC_PCR_MASK;
				end else if (a_reg == `SPC_OFF_TXDATA) begin
					s_nxt.txw[i] = wdata;
				end
			end

			// Reads; reading received data clears its flags
			if (rd && a_inst == 2'(i)) begin
				case (a_reg)
					`SPC_OFF_PCR: begin
						s_nxt.rdata = s_r.pin_control_register[i];
					end
					`SPC_OFF_RXDATA: begin
						s_nxt.rdata      = p_rx_word[i];
						s_nxt.rx_full[i] = 1'b0;
						s_nxt.rx_ovr[i]  = 1'b0;
					end
					`SPC_OFF_TXDATA: begin
						s_nxt.rdata = s_r.txw[i];
					end
					`SPC_OFF_STAT: begin
						s_nxt.rdata = {10'h000, p_lvl[i],
							s_r.rx_ovr[i], s_r.rx_full[i]};
					end
					default: begin
						s_nxt.rdata = 16'h0000;
					end
				endcase
			end

			// A word that lands in the clearing cycle still sets the flag
			if (p_rx_done[i]) begin
				s_nxt.rx_full[i] = 1'b1;
				if (s_r.rx_full[i]) begin
					s_nxt.rx_ovr[i] = 1'b1;
				end
			end

			// Receive clock pin: gpio, device-driven, or input
			if (s_r.pin_control_register[i][`SPC_PCR_RX_GPIO]) begin
				s_nxt.rck_o[i]  = s_r.pin_control_register[i][`SPC_PCR_RCK_VAL];
				s_nxt.rck_oe[i] = s_r.pin_control_register[i][`SPC_PCR_RCK_OE];
				s_nxt.rfs_o[i]  = s_r.pin_control_register[i][`SPC_PCR_RFS_VAL];
				s_nxt.rfs_oe[i] = s_r.pin_control_register[i][`SPC_PCR_RFS_OE];
			end else begin
				s_nxt.rck_o[i]  = p_int_clk[i];
				s_nxt.rck_oe[i] = s_r.pin_control_register[i][`SPC_PCR_RX_CLK_DIR];
				s_nxt.rfs_o[i]  = p_int_fs[i];
				s_nxt.rfs_oe[i] = s_r.pin_control_register[i][`SPC_PCR_RX_FS_DIR];
			end

			// Transmit clock pin: gpio, device-driven, or input
			if (s_r.pin_control_register[i][`SPC_PCR_TX_GPIO]) begin
				s_nxt.xck_o[i]  = s_r.pin_control_register[i][`SPC_PCR_XCK_VAL];
				s_nxt.xck_oe[i] = s_r.pin_control_register[i][`SPC_PCR_XCK_OE];
			end else begin
				s_nxt.xck_o[i]  = p_int_clk[i];
				s_nxt.xck_oe[i] = s_r.pin_control_register[i][`SPC_PCR_TX_CLK_DIR];
			end

			s_nxt.xdt_o[i]  = p_tx_bit[i];
			s_nxt.xdt_oe[i] = 1'b1;

			// Output-off overrides every enable
			if (!s_r.off_s[1]) begin
				s_nxt.rck_oe[i] = 1'b0;
				s_nxt.rfs_oe[i] = 1'b0;
				s_nxt.xck_oe[i] = 1'b0;
				s_nxt.xdt_oe[i] = 1'b0;
			end
		end
	end

	// Off sync resets low so pins stay released until off_n is seen high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from flops
	// ------------------------------------------------------------------
	assign rdata                = s_r.rdata;
	assign rx_bit_clock_pin_o   = s_r.rck_o;
	assign rx_bit_clock_pin_oe  = s_r.rck_oe;
	assign rx_frame_sync_pin_o  = s_r.rfs_o;
	assign rx_frame_sync_pin_oe = s_r.rfs_oe;
	assign tx_bit_clock_pin_o   = s_r.xck_o;
	assign tx_bit_clock_pin_oe  = s_r.xck_oe;
	assign tx_serial_data_o     = s_r.xdt_o;
	assign tx_serial_data_oe    = s_r.xdt_oe;

endmodule : spc_top

/* inc/spc_map.svh */
// Register offsets, field positions, reset values and timing counts
// for the serial port pin control block.
// Assumes inclusion by bare name from the package and design files.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define SPC_NUM_INST      3
`define SPC_WORD_BITS     16
`define SPC_FRAME_LAST    5'h0F
`define SPC_FS_PERIOD     5'h10

// ----------------------------------------------------------------------
// Register map: instance in addr[5:4], register in addr[3:0]
// ----------------------------------------------------------------------
`define SPC_OFF_PCR       4'h0
`define SPC_OFF_RXDATA    4'h4
`define SPC_OFF_TXDATA    4'h8
`define SPC_OFF_STAT      4'hC
`define SPC_PCR_RST       16'h0000
`define SPC_TXW_RST       16'h0000

// ----------------------------------------------------------------------
// Pin control register fields
// ----------------------------------------------------------------------
`define SPC_PCR_RX_CLK_DIR   0
`define SPC_PCR_TX_CLK_DIR   1
`define SPC_PCR_RX_FS_DIR    2
`define SPC_PCR_RX_GPIO      3
`define SPC_PCR_TX_GPIO      4
`define SPC_PCR_RCK_VAL      5
`define SPC_PCR_RFS_VAL      6
`define SPC_PCR_XCK_VAL      7
`define SPC_PCR_RCK_OE       8
`define SPC_PCR_RFS_OE       9
`define SPC_PCR_XCK_OE       10
`define SPC_PCR_MASK         16'h07FF

// ----------------------------------------------------------------------
// Timing: half period of the internally made bit clock, in mclk cycles
// ----------------------------------------------------------------------
`define SPC_CLKDIV_HALF   4'h8

`endif

/* inc/spc_pkg.sv */
// Types shared by the serial port pin control design files.
// Assumes spc_map.svh is on the include path.
`include "spc_map.svh"

package spc_pkg;

	typedef enum logic {
		SPC_RX_IDLE  = 1'b0,
		SPC_RX_SHIFT = 1'b1
	} spc_rx_state_t;

	typedef struct packed {
		logic [1:0]    rck_s;
		logic [1:0]    rdt_s;
		logic [1:0]    rfs_s;
		logic [1:0]    xck_s;
		logic          rck_d;
		logic          xck_d;
		logic [3:0]    div_cnt;
		logic          dclk;
		logic [4:0]    fs_cnt;
		logic          ifs;
		spc_rx_state_t rx_st;
		logic [4:0]    rx_cnt;
		logic [15:0]   rx_sh;
		logic [15:0]   rx_word;
		logic          rx_done;
		logic [15:0]   tx_sh;
		logic [4:0]    tx_cnt;
		logic          tx_bit;
	} spc_port_st_t;

	typedef struct packed {
		logic [1:0]       off_s;
		logic [2:0][15:0] pin_control_register;
		logic [2:0][15:0] txw;
		logic [2:0]       rx_full;
		logic [2:0]       rx_ovr;
		logic [15:0]      rdata;
		logic [2:0]       rck_o;
		logic [2:0]       rck_oe;
		logic [2:0]       rfs_o;
		logic [2:0]       rfs_oe;
		logic [2:0]       xck_o;
		logic [2:0]       xck_oe;
		logic [2:0]       xdt_o;
		logic [2:0]       xdt_oe;
	} spc_top_st_t;

endpackage : spc_pkg

/* design/spc_port.sv */
// One serial port instance: pin synchronisers, bit clock divider,
// receive shifter and transmit shifter.
// Assumes pin levels arrive asynchronously and mclk is the only clock.
module spc_port
	import spc_pkg::*;
(
	input  wire logic        mclk,          // System clock
	input  wire logic        rst_n,         // Async reset, active low
	input  wire logic        rx_clk_dir,    // 1: use internal rx clock
	input  wire logic        tx_clk_dir,    // 1: use internal tx clock
	input  wire logic        rx_fs_dir,     // 1: use internal frame sync
	input  wire logic        rx_gpio,       // Rx pins are general I/O
	input  wire logic        tx_gpio,       // Tx clock pin is general I/O
	input  wire logic [15:0] tx_word,       // Word to transmit
	input  wire logic        rck_pin,       // Rx bit clock pin level
	input  wire logic        rdt_pin,       // Rx data pin level
	input  wire logic        rfs_pin,       // Rx frame sync pin level
	input  wire logic        xck_pin,       // Tx bit clock pin level
	output logic             int_clk,       // Internal bit clock level
	output logic             int_fs,        // Internal frame sync level
	output logic             tx_bit,        // Serial transmit bit
	output logic      [15:0] rx_word,       // Last received word
	output logic             rx_done,       // Word received, one cycle
	output logic      [3:0]  pin_lvl        // Synced pin levels
);

	spc_port_st_t s_r;
	spc_port_st_t s_nxt;
	logic         dck_rise;
	logic         dck_fall;
	logic         rx_edge;
	logic         tx_edge;
	logic         fs_now;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_nxt         = s_r;
		s_nxt.rx_done = 1'b0;
		s_nxt.rck_s   = {s_r.rck_s[0], rck_pin};
		s_nxt.rdt_s   = {s_r.rdt_s[0], rdt_pin};
		s_nxt.rfs_s   = {s_r.rfs_s[0], rfs_pin};
		s_nxt.xck_s   = {s_r.xck_s[0], xck_pin};
		s_nxt.rck_d   = s_r.rck_s[1];
		s_nxt.xck_d   = s_r.xck_s[1];
		dck_rise      = 1'b0;
		dck_fall      = 1'b0;

		if (s_r.div_cnt == `SPC_CLKDIV_HALF - 4'h1) begin
			s_nxt.div_cnt = 4'h0;
			s_nxt.dclk    = ~s_r.dclk;
			dck_rise      = ~s_r.dclk;
			dck_fall      = s_r.dclk;
		end else begin
			s_nxt.div_cnt = s_r.div_cnt + 4'h1;
		end

		// Internal frame sync: one bit clock high, then sixteen low
		if (dck_rise) begin
			if (s_r.fs_cnt == `SPC_FS_PERIOD) begin
				s_nxt.fs_cnt = 5'h00;
			end else begin
				s_nxt.fs_cnt = s_r.fs_cnt + 5'h01;
			end
			s_nxt.ifs = (s_r.fs_cnt == `SPC_FS_PERIOD);
		end

		// Receiver shifts on the selected clock, never in gpio mode
		rx_edge = ~rx_gpio & (rx_clk_dir ? dck_rise :
			(s_r.rck_s[1] & ~s_r.rck_d));
		fs_now  = rx_fs_dir ? s_r.ifs : s_r.rfs_s[1];
		if (rx_gpio) begin
			s_nxt.rx_st = SPC_RX_IDLE;
		end else if (rx_edge) begin
			case (s_r.rx_st)
				SPC_RX_IDLE: begin
					if (fs_now) begin
						s_nxt.rx_st  = SPC_RX_SHIFT;
						s_nxt.rx_cnt = 5'h00;
					end
				end
				SPC_RX_SHIFT: begin
					s_nxt.rx_sh = {s_r.rx_sh[14:0], s_r.rdt_s[1]};
					if (s_r.rx_cnt == `SPC_FRAME_LAST) begin
						s_nxt.rx_st   = SPC_RX_IDLE;
						s_nxt.rx_word = {s_r.rx_sh[14:0], s_r.rdt_s[1]};
						s_nxt.rx_done = 1'b1;
					end else begin
						s_nxt.rx_cnt = s_r.rx_cnt + 5'h01;
					end
				end
				default: begin
					s_nxt.rx_st = SPC_RX_IDLE;
				end
			endcase
		end

		// Transmitter changes data on the falling clock edge
		tx_edge = ~tx_gpio & (tx_clk_dir ? dck_fall :
			(~s_r.xck_s[1] & s_r.xck_d));
		if (tx_edge) begin
			if (s_r.tx_cnt == 5'h00) begin
				s_nxt.tx_bit = tx_word[15];
				s_nxt.tx_sh  = {tx_word[14:0], 1'b0};
			end else begin
				s_nxt.tx_bit = s_r.tx_sh[15];
				s_nxt.tx_sh  = {s_r.tx_sh[14:0], 1'b0};
			end
			if (s_r.tx_cnt == `SPC_FRAME_LAST) begin
				s_nxt.tx_cnt = 5'h00;
			end else begin
				s_nxt.tx_cnt = s_r.tx_cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign int_clk = s_r.dclk;
	assign int_fs  = s_r.ifs;
	assign tx_bit  = s_r.tx_bit;
	assign rx_word = s_r.rx_word;
	assign rx_done = s_r.rx_done;
	assign pin_lvl = {s_r.xck_s[1], s_r.rfs_s[1], s_r.rdt_s[1], s_r.rck_s[1]};

endmodule : spc_port

/* verif/spc_top_checker.sv */
// Port-level checks for the serial port pin control block.
// Assumes binding to spc_top; everything runs on mclk.
module spc_top_checker (
	input wire logic        mclk,                 // System clock
	input wire logic        rst_n,                // Async reset
	input wire logic        off_n,                // Output-off
	input wire logic [7:0]  addr,                 // Byte address
	input wire logic [15:0] wdata,                // Write data
	input wire logic        wr,                   // Write strobe
	input wire logic        rd,                   // Read strobe
	input wire logic [15:0] rdata,                // Read data
	input wire logic [2:0]  rx_bit_clock_pin_o,   // Rx clock value
	input wire logic [2:0]  rx_bit_clock_pin_oe,  // Rx clock enable
	input wire logic [2:0]  rx_frame_sync_pin_oe, // Rx sync enable
	input wire logic [2:0]  tx_bit_clock_pin_o,   // Tx clock value
	input wire logic [2:0]  tx_bit_clock_pin_oe,  // Tx clock enable
	input wire logic [2:0]  tx_serial_data_oe     // Tx data enable
);
	// Saturating run lengths of output-off high and low
	logic [2:0] hi_r;
	logic [2:0] lo_r;
	logic       pcr0_wr;

	assign pcr0_wr = wr && addr == 8'h00;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hi_r <= 3'h0;
			lo_r <= 3'h0;
		end else begin
			hi_r <= !off_n ? 3'h0 : (hi_r == 3'h7 ? hi_r : hi_r + 3'h1);
			lo_r <= off_n ? 3'h0 : (lo_r == 3'h7 ? lo_r : lo_r + 3'h1);
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_OFF_RCK:
		assert property (lo_r >= 3'h4 |-> rx_bit_clock_pin_oe == 3'h0)
		else $error("rx clock pin driven while output-off");
	AST_OFF_OTH:
		assert property (!off_n [*4] |=> rx_frame_sync_pin_oe == 3'h0
			&& tx_bit_clock_pin_oe == 3'h0)
		else $error("sync or tx clock pin driven while output-off");
	AST_OFF_TDT:
		assert property ($fell(off_n) ##1 !off_n [*3]
			|-> tx_serial_data_oe == 3'h0)
		else $error("tx data pin driven while output-off");
	AST_TDT_ON:
		assert property (hi_r >= 3'h5 |-> tx_serial_data_oe == 3'h7)
		else $error("tx data pin not driven while outputs on");
	AST_RCK_OUT:
		assert property (pcr0_wr && wdata[0] && !wdata[3] && hi_r >= 3'h5
			|-> ##2 rx_bit_clock_pin_oe[0])
		else $error("rx clock pin not driven in output mode");
	AST_TCK_IN:
		assert property (pcr0_wr && !wdata[1] && !wdata[4]
			|-> ##2 !tx_bit_clock_pin_oe[0])
		else $error("tx clock pin driven in input mode");
	AST_RX_GPIO:
		assert property (pcr0_wr && wdata[3] && hi_r >= 3'h5 |-> ##2
			rx_bit_clock_pin_oe[0] == $past(wdata[8], 2)
			&& rx_bit_clock_pin_o[0] == $past(wdata[5], 2)
			&& rx_frame_sync_pin_oe[0] == $past(wdata[9], 2))
		else $error("rx pins do not follow gpio settings");
	AST_TX_GPIO:
		assert property (pcr0_wr && wdata[4] && hi_r >= 3'h5 |-> ##2
			tx_bit_clock_pin_oe[0] == $past(wdata[10], 2)
			&& tx_bit_clock_pin_o[0] == $past(wdata[7], 2))
		else $error("tx clock pin does not follow gpio settings");
	AST_BAD_RD:
		assert property (rd && addr[5:4] == 2'h3 |=> rdata == 16'h0000)
		else $error("read of missing instance returned data");
	AST_RD_IDLE:
		assert property (!rd |=> rdata == 16'h0000)
		else $error("read data present without a read");

	COV_OFF: cover property (lo_r == 3'h4);
	COV_GPIO: cover property (pcr0_wr && wdata[3] && wdata[4]);
	COV_RXRD: cover property (rd && addr == 8'h04);
endmodule : spc_top_checker

bind spc_top spc_top_checker u_spc_top_checker (
	.mclk(mclk), .rst_n(rst_n), .off_n(off_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.rx_bit_clock_pin_o(rx_bit_clock_pin_o),
	.rx_bit_clock_pin_oe(rx_bit_clock_pin_oe),
	.rx_frame_sync_pin_oe(rx_frame_sync_pin_oe),
	.tx_bit_clock_pin_o(tx_bit_clock_pin_o),
	.tx_bit_clock_pin_oe(tx_bit_clock_pin_oe),
	.tx_serial_data_oe(tx_serial_data_oe));

/* verif/spc_codec.sv */
// Behavioural serial peer: supplies bit clocks, frame sync and data.
// Assumes the bench resolves each two-way pin from the enables.
module spc_codec (
	output logic rck, // Rx bit clock, still outside frames
	output logic rfs, // Rx frame sync
	output logic rdt, // Rx serial data
	output logic xck  // Tx bit clock, same as rck
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		rck = 1'b0;
		rfs = 1'b0;
		rdt = 1'b0;
		xck = 1'b0;
	end

	// Sync edge, then 16 bits MSB first; data set while clock is low
	task automatic send(input logic [15:0] word);
		for (int i = 16; i >= 0; i--) begin
			rfs = (i == 16);
			rdt = (i == 16) ? ~rdt : word[i];
			#62.5 rck = 1'b1;
			xck = 1'b1;
			#62.5 rck = 1'b0;
			xck = 1'b0;
		end
		// Released line must not keep showing the last bit
		rdt = ~rdt;
	endtask : send
endmodule : spc_codec

/* verif/testbench.sv */
// Self-checking bench for the serial port pin control block.
// Assumes the checker is bound in and the peer drives instance 0.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk, rst_n, off_n, wr, rd, c_rck, c_rfs, c_rdt, c_xck;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, d;
	logic [2:0]  rck_o, rck_oe, rfs_o, rfs_oe, xck_o, xck_oe, xdt_o, xdt_oe;
	logic [2:0]  rck_i, rfs_i, xck_i;
	logic [47:0] txs;
	logic [15:0] found;
	int          failures, comparisons, cycles;

	// Pin level: design where it drives, else the peer (others low)
	assign rck_i = (rck_oe & rck_o) | (~rck_oe & {2'h0, c_rck});
	assign rfs_i = (rfs_oe & rfs_o) | (~rfs_oe & {2'h0, c_rfs});
	assign xck_i = (xck_oe & xck_o) | (~xck_oe & {2'h0, c_xck});

	spc_codec u_spc_codec (.rck(c_rck), .rfs(c_rfs), .rdt(c_rdt),
		.xck(c_xck));
	spc_top u_spc_top (.mclk(mclk), .rst_n(rst_n), .off_n(off_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rx_bit_clock_pin_i(rck_i), .rx_bit_clock_pin_o(rck_o),
		.rx_bit_clock_pin_oe(rck_oe), .rx_serial_data_pin_i({2'h0, c_rdt}),
		.rx_frame_sync_pin_i(rfs_i), .rx_frame_sync_pin_o(rfs_o),
		.rx_frame_sync_pin_oe(rfs_oe), .tx_bit_clock_pin_i(xck_i),
		.tx_bit_clock_pin_o(xck_o), .tx_bit_clock_pin_oe(xck_oe),
		.tx_serial_data_o(xdt_o), .tx_serial_data_oe(xdt_oe));

	always #4 mclk = ~mclk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// Ceiling well above the roughly 2000 cycles the tests take
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		off_n = 1'b1;
		{wr, rd, addr, wdata} = '0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		for (int i = 0; i < 3; i++) begin
			rd_reg({2'h0, i[1:0], 4'h0}, d);
			chk("pcr reset", d, 16'h0000);
			wr_reg({2'h0, i[1:0], 4'h0}, 16'hFFFF);
			rd_reg({2'h0, i[1:0], 4'h0}, d);
			chk("pcr mask", d, 16'h07FF);
			wr_reg({2'h0, i[1:0], 4'h0}, 16'h0000);
		end
		rd_reg(8'h30, d);
		chk("missing instance", d, 16'h0000);
		rd_reg(8'h02, d);
		chk("unmapped register", d, 16'h0000);
		wr_reg(8'h00, 16'h0001);
		chk("rx clock out", {15'h0, rck_oe[0]}, 16'h0001);
		chk("tx clock in", {15'h0, xck_oe[0]}, 16'h0000);
		wr_reg(8'h00, 16'h0018);
		chk("gpio off", {10'h0, rck_oe[0], rck_o[0], rfs_oe[0], rfs_o[0],
			xck_oe[0], xck_o[0]}, 16'h0000);
		wr_reg(8'h00, 16'h07F8);
		chk("gpio on", {10'h0, rck_oe[0], rck_o[0], rfs_oe[0], rfs_o[0],
			xck_oe[0], xck_o[0]}, 16'h003F);
		@(posedge mclk);
		off_n <= 1'b0;
		repeat (4) @(posedge mclk);
		#1 chk("off", {4'h0, rck_oe, rfs_oe, xck_oe, xdt_oe}, 16'h0000);
		off_n <= 1'b1;
		repeat (5) @(posedge mclk);
		#1 chk("on", {4'h0, rck_oe, rfs_oe, xck_oe, xdt_oe}, 16'h024F);
		// Frame arriving while the rx pins are gpio must be ignored
		wr_reg(8'h00, 16'h0018);
		u_spc_codec.send(16'h1234);
		rd_reg(8'h0C, d);
		chk("gpio rx full", d & 16'h0003, 16'h0000);
		wr_reg(8'h00, 16'h0000);
		u_spc_codec.send(16'hA5C3);
		repeat (8) @(posedge mclk);
		rd_reg(8'h0C, d);
		chk("rx full", d & 16'h0003, 16'h0001);
		rd_reg(8'h04, d);
		chk("rx word", d, 16'hA5C3);
		u_spc_codec.send(16'h3C5A);
		u_spc_codec.send(16'h0FF1);
		repeat (8) @(posedge mclk);
		rd_reg(8'h0C, d);
		chk("rx overrun", d & 16'h0003, 16'h0003);
		rd_reg(8'h04, d);
		chk("rx last word", d, 16'h0FF1);
		rd_reg(8'h0C, d);
		chk("rx cleared", d & 16'h0003, 16'h0000);
		wr_reg(8'h08, 16'hA5C3);
		wr_reg(8'h00, 16'h0002);
		chk("tx clock out", {15'h0, xck_oe[0]}, 16'h0001);
		for (int k = 0; k < 48; k++) begin
			@(posedge xck_o[0]);
			#1 txs = {txs[46:0], xdt_o[0]};
		end
		found = 16'h0000;
		for (int s = 0; s <= 32; s++)
			if (txs[s +: 16] === 16'hA5C3)
				found = 16'h0001;
		chk("tx word msb first", found, 16'h0001);
		close_out();
	end
endmodule : testbench
